/* logic/apt_regs.sv */
`timescale 1ns/1ps
module apt_regs (
  input  wire logic   clk_i,
  input  wire logic   rst_b_i,
  input  wire logic   link_clk_i,
  input  wire logic   cs_b_i,
  input  wire logic   ci_i,
  output logic        co_o,
  output logic        co_oe_o,
  input  wire logic   companded_i,
  input  wire logic   tx_override_sel_i,
  output logic [7:0]  tx_override_byte_o,
  output logic        tx_override_active_o,
  output logic [2:0]  mic_input_select_o,
  output logic        sidetone_en_o,
  output logic        earpiece_output_o,
  output logic        loudspeaker_output_o,
  output logic        tone_to_output_enable_o,
  output logic        receive_to_output_enable_o,
  output logic [5:0]  tx_gain_half_db_o,
  output logic [5:0]  sidetone_atten_half_db_o,
  output logic [4:0]  earpiece_gain_atten_db_o,
  output logic [4:0]  external_amp_gain_atten_db_o,
  output logic [4:0]  tone_atten_db_o,
  output logic [10:0] tone1_amp_mv_o,
  output logic [10:0] tone2_amp_mv_o,
  output logic        sine_wave_select_o,
  output logic        tone_to_transmit_enable_o,
  output logic [7:0]  first_tone_code_o,
  output logic [7:0]  second_tone_code_o,
  output logic [1:0]  tone_range_o
);

  apt_xfer_if xfer ();

  logic [2:0] wr_sync;
  logic       wr_evt;
  logic       snap_tgl;
  logic [7:0] tx_override_byte;
  logic [7:0] path_routing_control;
  logic [7:0] mic_and_sidetone_gain;
  logic [7:0] output_attenuation;
  logic [7:0] tone_generator_control;
  logic [7:0] first_tone_frequency_code;
  logic [7:0] second_tone_frequency_code;
  logic [1:0] tone_range_control;

  // ****************************************************************
  // link side: serial shifting on the link clock
  // ****************************************************************
  apt_link u_link (
    .clk_link_i (link_clk_i),
    .rst_b_i    (rst_b_i),
    .cs_b_i     (cs_b_i),
    .ci_i       (ci_i),
    .co_o       (co_o),
    .co_oe_o    (co_oe_o),
    .xfer       (xfer.link)
  );

  // ****************************************************************
  // write event crossing
  // ****************************************************************

  // the word is held by the link side from the toggle until the next frame
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      wr_sync <= 3'h0;
    else
      wr_sync <= {wr_sync[1:0], xfer.wr_tgl};
  end
  assign wr_evt = wr_sync[2] ^ wr_sync[1];

  // ****************************************************************
  // register file
  // ****************************************************************

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      tx_override_byte           <= apt_pkg::RST_REG;
      path_routing_control       <= apt_pkg::RST_REG;
      mic_and_sidetone_gain      <= apt_pkg::RST_REG;
      output_attenuation         <= apt_pkg::RST_REG;
      tone_generator_control     <= apt_pkg::RST_REG;
      first_tone_frequency_code  <= apt_pkg::RST_REG;
      second_tone_frequency_code <= apt_pkg::RST_REG;
      tone_range_control         <= apt_pkg::RST_RANGE;
    end
    else if (wr_evt)
    begin
      case (xfer.wr_addr)
        apt_pkg::ADDR_TX_OVERRIDE: tx_override_byte <= xfer.wr_data;
        apt_pkg::ADDR_ROUTING:
        begin
          path_routing_control                       <= xfer.wr_data;
          path_routing_control[apt_pkg::RT_RESERVED] <= 1'b0;
        end
        apt_pkg::ADDR_GAIN:        mic_and_sidetone_gain      <= xfer.wr_data;
        apt_pkg::ADDR_ATTEN:       output_attenuation         <= xfer.wr_data;
        apt_pkg::ADDR_TONE_CTL:    tone_generator_control     <= xfer.wr_data;
        apt_pkg::ADDR_TONE1:       first_tone_frequency_code  <= xfer.wr_data;
        apt_pkg::ADDR_TONE2:       second_tone_frequency_code <= xfer.wr_data;
        apt_pkg::ADDR_RANGE:       tone_range_control         <= xfer.wr_data[1:0];
        default:                   tone_range_control         <= tone_range_control;
      endcase
    end
  end

  // ****************************************************************
  // read-back image for the link side
  // ****************************************************************

  // image toggles on the same edge the stored contents change
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      snap_tgl <= 1'b0;
    else
      snap_tgl <= snap_tgl ^ wr_evt;
  end
  assign xfer.snap_tgl = snap_tgl;

  // override byte is write only and reads back as zero
  assign xfer.snap[0] = 8'h00;
  assign xfer.snap[1] = path_routing_control;
  assign xfer.snap[2] = mic_and_sidetone_gain;
  assign xfer.snap[3] = output_attenuation;
  assign xfer.snap[4] = tone_generator_control;
  assign xfer.snap[5] = first_tone_frequency_code;
  assign xfer.snap[6] = second_tone_frequency_code;
  assign xfer.snap[7] = {6'h00, tone_range_control};

  // ****************************************************************
  // transmit override and routing decode
  // ****************************************************************

  // override only has meaning with companded coding
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      tx_override_byte_o   <= apt_pkg::RST_REG;
      tx_override_active_o <= 1'b0;
    end
    else
    begin
      tx_override_byte_o   <= tx_override_byte;
      tx_override_active_o <= companded_i & tx_override_sel_i;
    end
  end

  // one-hot microphone pick, zero is muted
  // code 11 is treated as muted so both outputs never drive
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      mic_input_select_o         <= 3'h0;
      sidetone_en_o              <= 1'b0;
      earpiece_output_o          <= 1'b0;
      loudspeaker_output_o       <= 1'b0;
      tone_to_output_enable_o    <= 1'b0;
      receive_to_output_enable_o <= 1'b0;
    end
    else
    begin
      case (path_routing_control[7:6])
        2'b01:   mic_input_select_o <= 3'h1;
        2'b10:   mic_input_select_o <= 3'h2;
        2'b11:   mic_input_select_o <= 3'h4;
        default: mic_input_select_o <= 3'h0;
      endcase
      sidetone_en_o              <= path_routing_control[apt_pkg::RT_SIDETONE];
      earpiece_output_o          <= path_routing_control[4:3] == 2'b01;
      loudspeaker_output_o       <= path_routing_control[4:3] == 2'b10;
      tone_to_output_enable_o    <= path_routing_control[apt_pkg::RT_TONE_OUT];
      receive_to_output_enable_o <= path_routing_control[apt_pkg::RT_RX_OUT];
    end
  end

  // ****************************************************************
  // amplifier gains
  // ****************************************************************

  // mic gain and sidetone in half-dB units
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      tx_gain_half_db_o            <= 6'h00;
      sidetone_atten_half_db_o     <= apt_pkg::ST_BASE_HALF_DB;
      earpiece_gain_atten_db_o     <= 5'h00;
      external_amp_gain_atten_db_o <= 5'h00;
    end
    else
    begin
      tx_gain_half_db_o            <= {2'h0, mic_and_sidetone_gain[7:4]} * apt_pkg::TX_STEP_HALF_DB;
      sidetone_atten_half_db_o     <= apt_pkg::ST_BASE_HALF_DB + {1'b0, mic_and_sidetone_gain[3:0], 1'b0};
      earpiece_gain_atten_db_o     <= {output_attenuation[7:4], 1'b0};
      external_amp_gain_atten_db_o <= {output_attenuation[3:0], 1'b0};
    end
  end

  // ****************************************************************
  // tone generator controls
  // ****************************************************************

  // codes of eight and above all give the deepest step
  // summing drops both amplitudes to keep the sum in range
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      tone_atten_db_o           <= 5'h00;
      tone1_amp_mv_o            <= 11'h000;
      tone2_amp_mv_o            <= 11'h000;
      sine_wave_select_o        <= 1'b0;
      tone_to_transmit_enable_o <= 1'b0;
    end
    else
    begin
      if (tone_generator_control[7])
        tone_atten_db_o <= apt_pkg::TONE_MAX_DB;
      else
        tone_atten_db_o <= {2'h0, tone_generator_control[6:4]} * apt_pkg::TONE_STEP_DB;
      case (tone_generator_control[3:2])
        2'b01:
        begin
          tone1_amp_mv_o <= 11'h000;
          tone2_amp_mv_o <= apt_pkg::TONE2_FULL_MV;
        end
        2'b10:
        begin
          tone1_amp_mv_o <= apt_pkg::TONE1_FULL_MV;
          tone2_amp_mv_o <= 11'h000;
        end
        2'b11:
        begin
          tone1_amp_mv_o <= apt_pkg::TONE1_SUM_MV;
          tone2_amp_mv_o <= apt_pkg::TONE2_SUM_MV;
        end
        default:
        begin
          tone1_amp_mv_o <= 11'h000;
          tone2_amp_mv_o <= 11'h000;
        end
      endcase
      sine_wave_select_o        <= tone_generator_control[apt_pkg::TC_SINE];
      tone_to_transmit_enable_o <= tone_generator_control[apt_pkg::TC_INJECT];
    end
  end

  // forbidden range code falls back to standard
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      first_tone_code_o  <= apt_pkg::RST_REG;
      second_tone_code_o <= apt_pkg::RST_REG;
      tone_range_o       <= apt_pkg::APT_RANGE_STD;
    end
    else
    begin
      first_tone_code_o  <= first_tone_frequency_code;
      second_tone_code_o <= second_tone_frequency_code;
      case (tone_range_control)
        2'b01:   tone_range_o <= apt_pkg::APT_RANGE_HALF;
        2'b10:   tone_range_o <= apt_pkg::APT_RANGE_DOUBLE;
        default: tone_range_o <= apt_pkg::APT_RANGE_STD;
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_override_gate: assert property (
    tx_override_active_o == $past(companded_i && tx_override_sel_i))
    else $error("override active does not follow coding and select");

  chk_mic_decode: assert property (
    $onehot0(mic_input_select_o) && mic_input_select_o == 3'((4'h1 << $past(path_routing_control[7:6])) >> 1))
    else $error("microphone pick decoded wrongly");

  chk_routing_write: assert property (
    wr_evt && xfer.wr_addr == apt_pkg::ADDR_ROUTING |=> ##1
      sidetone_en_o == $past(xfer.wr_data[5], 2) && tone_to_output_enable_o == $past(xfer.wr_data[2], 2)
      && receive_to_output_enable_o == $past(xfer.wr_data[0], 2))
    else $error("routing outputs late or wrong after write");

  chk_output_excl: assert property (
    !(earpiece_output_o && loudspeaker_output_o))
    else $error("both audio outputs selected");

  chk_tx_gain: assert property (
    tx_gain_half_db_o <= 6'h2D && tx_gain_half_db_o == 6'($past(mic_and_sidetone_gain[7:4]) * 3))
    else $error("transmit gain out of scale");

  chk_ear_atten: assert property (
    earpiece_gain_atten_db_o <= apt_pkg::OUT_MAX_DB
    && earpiece_gain_atten_db_o == 5'($past(output_attenuation[7:4]) * 2))
    else $error("earpiece attenuation wrong");

  chk_tone_atten: assert property (
    tone_atten_db_o <= apt_pkg::TONE_MAX_DB && tone_atten_db_o == ($past(tone_generator_control[7]) ?
      apt_pkg::TONE_MAX_DB : 5'($past(tone_generator_control[6:4]) * 3)))
    else $error("tone attenuation beyond deepest step");

  chk_summed_amp: assert property (
    tone_generator_control[3:2] == 2'b11 |=> tone1_amp_mv_o == apt_pkg::TONE1_SUM_MV
      && tone2_amp_mv_o == apt_pkg::TONE2_SUM_MV)
    else $error("summed tone amplitudes wrong");

  chk_tone1_write: assert property (
    wr_evt && xfer.wr_addr == apt_pkg::ADDR_TONE1 |=> ##1 first_tone_code_o == $past(xfer.wr_data, 2))
    else $error("first tone code not updated");

  chk_readback_tgl: assert property (
    wr_evt |=> snap_tgl != $past(snap_tgl))
    else $error("read-back image not announced");

  chk_range_decode: assert property (
    $past(tone_range_control) inside {2'b00, 2'b11} |-> tone_range_o == apt_pkg::APT_RANGE_STD)
    else $error("range decode wrong");

  chk_power_on: assert property (
    disable iff (1'b0) !rst_b_i |=> !sine_wave_select_o && !tone_to_transmit_enable_o
      && mic_input_select_o == 3'h0 && tx_gain_half_db_o == 6'h00)
    else $error("power-on values wrong");

endmodule : apt_regs

/* logic/apt_pkg.sv */
package apt_pkg;

  // ****************************************************************
  // instruction first byte layout
  // ****************************************************************
  localparam int unsigned FB_ADDR_MSB = 6;
  localparam int unsigned FB_ADDR_LSB = 3;
  localparam int unsigned FB_READ_BIT = 2;
  localparam int unsigned FB_TWO_BIT  = 1;
  localparam logic [4:0]  BIT_LAST_FB = 5'h07;   // count at the last first-byte bit
  localparam logic [4:0]  BIT_LAST_SB = 5'h0F;   // count at the last second-byte bit

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [3:0] ADDR_TX_OVERRIDE = 4'h3;
  localparam logic [3:0] ADDR_ROUTING     = 4'h4;
  localparam logic [3:0] ADDR_GAIN        = 4'h5;
  localparam logic [3:0] ADDR_ATTEN       = 4'h6;
  localparam logic [3:0] ADDR_TONE_CTL    = 4'h7;
  localparam logic [3:0] ADDR_TONE1       = 4'h8;
  localparam logic [3:0] ADDR_TONE2       = 4'h9;
  localparam logic [3:0] ADDR_RANGE       = 4'hA;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int unsigned RT_SIDETONE = 5;
  localparam int unsigned RT_TONE_OUT = 2;
  localparam int unsigned RT_RESERVED = 1;
  localparam int unsigned RT_RX_OUT   = 0;
  localparam int unsigned TC_SINE     = 1;
  localparam int unsigned TC_INJECT   = 0;
  localparam logic [7:0]  RST_REG     = 8'h00;
  localparam logic [1:0]  RST_RANGE   = 2'h0;

  // ****************************************************************
  // gain scaling (half-dB units for the mic path, dB elsewhere)
  // ****************************************************************
  localparam logic [5:0] TX_STEP_HALF_DB = 6'h03;  // 1.5 dB
  localparam logic [5:0] ST_BASE_HALF_DB = 6'h19;  // 12.5 dB attenuation
  localparam logic [4:0] TONE_STEP_DB    = 5'h03;
  localparam logic [4:0] TONE_MAX_DB     = 5'h18;  // 24 dB
  localparam logic [4:0] OUT_MAX_DB      = 5'h1E;  // 30 dB

  // tone amplitudes in millivolts peak to peak
  localparam logic [10:0] TONE1_FULL_MV = 11'h640;  // 1600
  localparam logic [10:0] TONE2_FULL_MV = 11'h4EC;  // 1260
  localparam logic [10:0] TONE1_SUM_MV  = 11'h37A;  // 890
  localparam logic [10:0] TONE2_SUM_MV  = 11'h2BC;  // 700

  typedef enum logic [1:0] {
    APT_RANGE_STD    = 2'b00,
    APT_RANGE_HALF   = 2'b01,
    APT_RANGE_DOUBLE = 2'b10
  } apt_range_t;

endpackage : apt_pkg

/* logic/apt_xfer_if.sv */
`timescale 1ns/1ps
// write words travel link->core, register images core->link
interface apt_xfer_if;
  logic [3:0]      wr_addr;
  logic [7:0]      wr_data;
  logic            wr_tgl;
  logic            snap_tgl;
  logic [7:0][7:0] snap;

  modport link (output wr_addr, wr_data, wr_tgl, input snap_tgl, snap);
  modport core (input wr_addr, wr_data, wr_tgl, output snap_tgl, snap);
endinterface : apt_xfer_if

/* logic/apt_link.sv */
`timescale 1ns/1ps
module apt_link (
  input  wire logic   clk_link_i,
  input  wire logic   rst_b_i,
  input  wire logic   cs_b_i,
  input  wire logic   ci_i,
  output logic        co_o,
  output logic        co_oe_o,
  apt_xfer_if.link    xfer
);

  logic [1:0]      rst_sync;
  logic            link_rst_b;
  logic [2:0]      snap_sync;
  logic [7:0][7:0] shadow;
  logic [4:0]      bit_cnt;
  logic [6:0]      shift_in;
  logic [7:0]      first_byte;
  logic [7:0]      shift_out;
  logic            rd_active;
  logic [7:0]      next_first;

  // ****************************************************************
  // reset and register image crossing
  // ****************************************************************
  always_ff @(posedge clk_link_i)
  begin
    rst_sync <= {rst_sync[0], rst_b_i};
  end
  assign link_rst_b = rst_sync[1];

  // image is stable when its toggle lands, so it is sampled only then
  always_ff @(posedge clk_link_i)
  begin
    if (!link_rst_b)
    begin
      snap_sync <= 3'h0;
      shadow    <= '0;
    end
    else
    begin
      snap_sync <= {snap_sync[1:0], xfer.snap_tgl};
      if (snap_sync[2] ^ snap_sync[1])
        shadow <= xfer.snap;
    end
  end

  // ****************************************************************
  // frame shifter, cleared by the frame select itself
  // ****************************************************************
  assign next_first = {shift_in, ci_i};

  always_ff @(posedge clk_link_i or posedge cs_b_i)
  begin
    if (cs_b_i)
    begin
      bit_cnt    <= 5'h00;
      shift_in   <= 7'h00;
      first_byte <= 8'h00;
      shift_out  <= 8'h00;
      rd_active  <= 1'b0;
    end
    else if (!link_rst_b)
    begin
      bit_cnt    <= 5'h00;
      shift_in   <= 7'h00;
      first_byte <= 8'h00;
      shift_out  <= 8'h00;
      rd_active  <= 1'b0;
    end
    else
    begin
      shift_in <= next_first[6:0];
      if (bit_cnt <= apt_pkg::BIT_LAST_SB)
        bit_cnt <= bit_cnt + 5'h01;
      if (bit_cnt == apt_pkg::BIT_LAST_FB)
      begin
        first_byte <= next_first;
        rd_active  <= next_first[apt_pkg::FB_READ_BIT] & next_first[apt_pkg::FB_TWO_BIT];
        if (next_first[apt_pkg::FB_ADDR_MSB:apt_pkg::FB_ADDR_LSB] >= apt_pkg::ADDR_TX_OVERRIDE &&
            next_first[apt_pkg::FB_ADDR_MSB:apt_pkg::FB_ADDR_LSB] <= apt_pkg::ADDR_RANGE)
          shift_out <= shadow[3'(next_first[apt_pkg::FB_ADDR_MSB:apt_pkg::FB_ADDR_LSB] - 4'h3)];
        else
          shift_out <= 8'h00;
      end
      else
        shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  assign co_o    = shift_out[7];
  assign co_oe_o = rd_active;

  // ****************************************************************
  // completed write word handed to the core
  // ****************************************************************
  always_ff @(posedge clk_link_i)
  begin
    if (!link_rst_b)
    begin
      xfer.wr_addr <= 4'h0;
      xfer.wr_data <= 8'h00;
      xfer.wr_tgl  <= 1'b0;
    end
    else if (!cs_b_i && bit_cnt == apt_pkg::BIT_LAST_SB &&
             !first_byte[apt_pkg::FB_READ_BIT] && first_byte[apt_pkg::FB_TWO_BIT])
    begin
      xfer.wr_addr <= first_byte[apt_pkg::FB_ADDR_MSB:apt_pkg::FB_ADDR_LSB];
      xfer.wr_data <= next_first;
      xfer.wr_tgl  <= ~xfer.wr_tgl;
    end
  end

endmodule : apt_link

/* verif/apt_ctl_model.sv */
`timescale 1ns/1ps
// serial controller: link clock runs only inside frames and during idle calls
module apt_ctl_model (
  output logic       link_clk_o,
  output logic       cs_b_o,
  output logic       ci_o,
  output logic [7:0] rd_byte_o,
  output logic       rd_valid_o,
  input  wire logic  co_i,
  input  wire logic  co_oe_i
);
  logic co_hold;
  // a released read pin shows the inverse of its last level, never a stale copy
  wire  co_seen = co_oe_i ? co_i : ~co_hold;

  initial
  begin
    link_clk_o = 1'b0;
    cs_b_o     = 1'b1;
    ci_o       = 1'b0;
    rd_byte_o  = 8'h00;
    rd_valid_o = 1'b0;
    co_hold    = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n)
    begin
      #3 link_clk_o = 1'b1;
      #3 link_clk_o = 1'b0;
    end
  endtask : idle

  task automatic frame(input logic rd, input logic [3:0] addr, input logic [7:0] wd);
    logic [15:0] word;
    logic [7:0]  rdata;
    word   = {1'b0, addr, rd, 1'b1, 1'b0, wd};
    rdata  = 8'h00;
    cs_b_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      ci_o = word[i];
      #3 link_clk_o = 1'b1;
      #2 co_hold = co_seen;
      if (i >= 1 && i <= 8)
        rdata[i-1] = co_seen;
      #1 link_clk_o = 1'b0;
    end
    #3 cs_b_o = 1'b1;
    ci_o = ~ci_o;
    if (rd)
    begin
      rd_byte_o  = rdata;
      rd_valid_o = 1'b1;
      #1 rd_valid_o = 1'b0;
    end
  endtask : frame
endmodule : apt_ctl_model

/* verif/tb_audio_path_tone_config_regs.sv */
`timescale 1ns/1ps
module tb_audio_path_tone_config_regs;
  logic        clk_i, rst_b_i, companded_i, tx_override_sel_i, link_clk, cs_b, ci, co, co_oe, rd_valid;
  logic        tx_act, side, ear, ls, tone_out, rx_out, sine, inj;
  logic [7:0]  tx_byte, code1, code2, rd_byte, d;
  logic [2:0]  mic;
  logic [5:0]  tx_gain, st_att;
  logic [4:0]  ear_att, ext_att, tone_att;
  logic [10:0] amp1, amp2;
  logic [1:0]  rng;
  logic [31:0] seed, r;
  logic [7:0]  exp_q[$];
  int          bad_count, n_checks;

  apt_regs dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk), .cs_b_i(cs_b), .ci_i(ci),
    .co_o(co), .co_oe_o(co_oe), .companded_i(companded_i), .tx_override_sel_i(tx_override_sel_i),
    .tx_override_byte_o(tx_byte), .tx_override_active_o(tx_act), .mic_input_select_o(mic),
    .sidetone_en_o(side), .earpiece_output_o(ear), .loudspeaker_output_o(ls),
    .tone_to_output_enable_o(tone_out), .receive_to_output_enable_o(rx_out), .tx_gain_half_db_o(tx_gain),
    .sidetone_atten_half_db_o(st_att), .earpiece_gain_atten_db_o(ear_att),
    .external_amp_gain_atten_db_o(ext_att), .tone_atten_db_o(tone_att), .tone1_amp_mv_o(amp1),
    .tone2_amp_mv_o(amp2), .sine_wave_select_o(sine), .tone_to_transmit_enable_o(inj),
    .first_tone_code_o(code1), .second_tone_code_o(code2), .tone_range_o(rng));

  apt_ctl_model ctl (.link_clk_o(link_clk), .cs_b_o(cs_b), .ci_o(ci), .rd_byte_o(rd_byte),
    .rd_valid_o(rd_valid), .co_i(co), .co_oe_i(co_oe));

  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // expected decode of each register, worked out from the field tables
  task automatic check_reg(input logic [3:0] a, input logic [7:0] v);
    logic [3:0]  m;
    logic [4:0]  att;
    logic [21:0] amp;
    m   = 4'h8 >> (3'h4 - {1'b0, v[7:6]});
    att = (v[7] == 1'b1) ? 5'h18 : {1'b0, v[7:4]} * 5'h03;
    amp = (v[3:2] == 2'h0) ? 22'h0 : (v[3:2] == 2'h1) ? {11'h0, 11'h4EC} :
          (v[3:2] == 2'h2) ? {11'h640, 11'h0} : {11'h37A, 11'h2BC};
    case (a)
      4'h3: cmp(64'({tx_byte, tx_act}), 64'({v, companded_i & tx_override_sel_i}));
      4'h4: cmp(64'({mic, side, ear, ls, tone_out, rx_out}),
                64'({m[2:0], v[5], v[4:3] == 2'h1, v[4:3] == 2'h2, v[2], v[0]}));
      4'h5: cmp(64'({tx_gain, st_att}), 64'({{2'h0, v[7:4]} * 6'h03, 6'h19 + {1'b0, v[3:0], 1'b0}}));
      4'h6: cmp(64'({ear_att, ext_att}), 64'({v[7:4], 1'b0, v[3:0], 1'b0}));
      4'h7: cmp(64'({tone_att, amp1, amp2, sine, inj}), 64'({att, amp, v[1], v[0]}));
      4'h8: cmp(64'(code1), 64'(v));
      4'h9: cmp(64'(code2), 64'(v));
      4'hA: cmp(64'(rng), 64'((v[1:0] == 2'h3) ? 2'h0 : v[1:0]));
      default: ;
    endcase
  endtask : check_reg

  // read-back results are matched in order against the notes of the driver
  always @(posedge rd_valid)
    cmp(64'(rd_byte), 64'(exp_q.pop_front()));

  // core clock, free running
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // generous span: each register pass takes a little over 0.4 microseconds
  initial
  begin
    #50000;
    bad_count++;
    end_of_test();
  end

  // write each register, check its decode, then read it back
  initial
  begin
    seed = 32'hf0be;
    rst_b_i = 1'b0;
    companded_i = 1'b0;
    tx_override_sel_i = 1'b0;
    fork
      ctl.idle(16);
      repeat (20) @(posedge clk_i);
    join
    @(posedge clk_i) rst_b_i <= 1'b1;
    ctl.idle(4);
    // power-on decode, then codes and range at standard
    cmp(64'({mic, side, ear, ls, tone_out, rx_out, tx_gain, st_att, ear_att, ext_att, tone_att, amp1, amp2,
             sine, inj}), 64'(6'h19) << 39);
    cmp(64'({tx_byte, tx_act, code1, code2, rng}), 64'h0);
    for (int p = 0; p < 3; p++)
      for (int a = 3; a <= 11; a++)
      begin
        r = $random(seed);
        d = r[15:8];
        @(posedge clk_i)
        begin
          companded_i <= r[0];
          tx_override_sel_i <= r[1];
        end
        // no output code 11, reserved bits written as zero
        if (a == 4)
          d = {d[7:5], d[4] & ~d[3], d[3:2], 1'b0, d[0]};
        if (a == 10)
          d = {6'h00, d[1:0]};
        // first pass reaches the deepest step and summed tones
        if (a == 7 && p == 0)
          d = d | 8'h8C;
        ctl.frame(1'b0, 4'(a), d);
        repeat (16) @(posedge clk_i);
        #1 check_reg(4'(a), d);
        #60;
        exp_q.push_back((a == 3 || a == 11) ? 8'h00 : d);
        ctl.frame(1'b1, 4'(a), 8'h00);
        #60;
      end
    end_of_test();
  end
endmodule : tb_audio_path_tone_config_regs
